// File: smi_aux_defines.svh
// register indices, field positions and reset values for the smi auxiliary block
`ifndef SMI_AUX_DEFINES_SVH
`define SMI_AUX_DEFINES_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define AUX_IDX_SMI_EN_ONE 8'hB4
`define AUX_IDX_SMI_EN_TWO 8'hB5
`define AUX_IDX_SMI_STAT_ONE 8'hB6
`define AUX_IDX_SMI_STAT_TWO 8'hB7
`define AUX_IDX_RSVD_STANDBY 8'hB8
`define AUX_IDX_PIN_MUX 8'hC0
`define AUX_IDX_FORCED_CHG 8'hC1
`define AUX_IDX_EVT_STATUS 8'hD0
`define AUX_IDX_EVT_MASK 8'hD1

// ==========================================================
// field positions
`define AUX_BIT_PARALLEL 1
`define AUX_BIT_SERIAL_TWO 2
`define AUX_BIT_SERIAL_ONE 3
`define AUX_BIT_FLOPPY 4
`define AUX_BIT_WATCHDOG 7
`define AUX_BIT_MOUSE 0
`define AUX_BIT_KEYBOARD 1
`define AUX_BIT_INFRARED 2
`define AUX_BIT_KBC_P12 4
`define AUX_BIT_DMA3_SEL 1
`define AUX_BIT_KBC_SEL 3
`define AUX_BIT_FORCE_CHG 0
`define AUX_BIT_EVT_IR 0
`define AUX_BIT_EVT_FORCE_CLR 1

// ==========================================================
// writable masks and reset values
`define AUX_MASK_EN_ONE 8'h9E
`define AUX_MASK_EN_TWO 8'h57
`define AUX_MASK_PIN_MUX 8'h0A
`define AUX_MASK_EVT 8'h03
// status two source enables only, smi routing bit kept out of the or
`define AUX_MASK_EVT_TWO_SRC 8'h17
`define AUX_RST_EN_ONE 8'h00
`define AUX_RST_EN_TWO 8'h02
`define AUX_RST_PIN_MUX 8'h02
`define AUX_RST_FORCED_CHG 1'b1
`define AUX_RST_EVT 8'h00

`endif

// File: smi_aux_pkg.sv
// types shared by the smi auxiliary block
`default_nettype none

package smi_aux_pkg;

    // ==========================================================
    // peripheral request levels, high while asserted
    typedef struct packed {
        logic second_serial_irq_flag;
        logic first_serial_irq_flag;
        logic floppy_irq_flag;
        logic watchdog_flag;
        logic mouse_irq_flag;
        logic keyboard_irq_flag;
        logic kbc_port1_bit2_flag;
    } irq_sources_t;

    // ==========================================================
    // floppy drive pins seen by the forced change logic
    typedef struct packed {
        logic head_step_n;
        logic drive_select_zero_n;
        logic media_change_in_n;
    } floppy_pins_t;

    // ==========================================================
    // edge detector state
    typedef struct packed {
        logic primed;
        logic prev;
    } edge_state_t;

    // ==========================================================
    // main block state
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic ir_flag;
        logic force_chg;
        logic [7:0] pin_mux;
        logic [7:0] smi_en_one;
        logic [7:0] smi_en_two;
        logic [7:0] evt_status;
        logic [7:0] evt_mask;
    } aux_state_t;

endpackage

`default_nettype wire

// File: smi_aux_edge.sv
// transition detector for the selected infrared receive line
`default_nettype none

module smi_aux_edge
    import smi_aux_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic level_in,
    output logic transition
);

    edge_state_t st_reg;
    edge_state_t st_next;

    // ==========================================================
    // edge detect
    // no edge reported until one sample is held, so reset never fakes one
    always_comb begin
        st_next = st_reg;
        st_next.primed = 1'b1;
        st_next.prev = level_in;
        transition = st_reg.primed && (level_in != st_reg.prev);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// File: smi_aux_top.sv
// smi status, pin multiplex and forced disk change registers over avalon-mm
// Operation
// - status one shows parallel at bit 1, serial two at 2, serial one at 3, floppy at 4, watchdog at 7.
// - status one flags follow their sources and no software access clears them.
// - the parallel flag reads one while the port is inactive and tracks acknowledge once active.
// - an active parallel port drives its flag straight from the acknowledge level, unlatched.
// - status two shows mouse at bit 0, keyboard at 1 and kbc port 1 bit 2 at 4, cleared at source.
// - status two bit 2 is set by any transition on the infrared line chosen by the input mux.
// - reading status two clears the infrared flag and leaves the other flags alone.
// - software writing one sets the forced change latch and writing zero does not clear it.
// - a step with drive select zero asserted clears the forced change latch.
// - the media changed bit is the change input or'ed with drive select zero and'ed with the latch.
// - a status flag reaches the smi output only when its enable bit is one.
//
// The Avalon-MM slave port was decided locally.
`include "smi_aux_defines.svh"
`default_nettype none

module smi_aux_top
    import smi_aux_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hard_reset,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire irq_sources_t sources,
    input wire logic parallel_port_active,
    input wire logic printer_acknowledge_n,
    input wire logic ir_input_select,
    input wire logic infrared_receive_in,
    input wire logic second_serial_receive_in,
    input wire floppy_pins_t floppy_pins,
    output logic media_changed_bit,
    output logic system_mgmt_irq_n,
    output logic dma3_select,
    output logic kbc_select,
    output logic irq
);

    aux_state_t st_reg;
    aux_state_t st_next;

    // ==========================================================
    // decode helpers
    function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // ==========================================================
    // infrared input mux and transition detector
    logic ir_selected;
    logic ir_edge;

    assign ir_selected = ir_input_select ? infrared_receive_in : second_serial_receive_in;

    smi_aux_edge ir_edge_det (
        .clk(clk),
        .srst(srst),
        .level_in(ir_selected),
        .transition(ir_edge)
    );

    // ==========================================================
    // live status views
    logic parallel_port_irq_flag;
    logic [7:0] stat_one;
    logic [7:0] stat_two;

    assign parallel_port_irq_flag = parallel_port_active ? printer_acknowledge_n : 1'b1;

    always_comb begin
        stat_one = 8'h00;
        stat_one[`AUX_BIT_PARALLEL] = parallel_port_irq_flag;
        stat_one[`AUX_BIT_SERIAL_TWO] = sources.second_serial_irq_flag;
        stat_one[`AUX_BIT_SERIAL_ONE] = sources.first_serial_irq_flag;
        stat_one[`AUX_BIT_FLOPPY] = sources.floppy_irq_flag;
        stat_one[`AUX_BIT_WATCHDOG] = sources.watchdog_flag;
    end

    always_comb begin
        stat_two = 8'h00;
        stat_two[`AUX_BIT_MOUSE] = sources.mouse_irq_flag;
        stat_two[`AUX_BIT_KEYBOARD] = sources.keyboard_irq_flag;
        stat_two[`AUX_BIT_INFRARED] = st_reg.ir_flag;
        stat_two[`AUX_BIT_KBC_P12] = sources.kbc_port1_bit2_flag;
    end

    // ==========================================================
    // bus handshake
    // one wait state: data is captured first, then the access completes
    logic req;
    logic acc;
    logic wr_acc;
    logic rd_acc;

    assign req = read || write;
    assign acc = req && st_reg.ack;
    assign wr_acc = acc && write && byteenable[0];
    assign rd_acc = acc && read;
    assign waitrequest = req && !st_reg.ack;
    assign readdata = {24'h000000, st_reg.rdata};

    // ==========================================================
    // read mux
    logic [7:0] rd_value;

    // unmapped and reserved read as zero
    always_comb begin
        rd_value = 8'h00;
        if (reg_hit(address, `AUX_IDX_SMI_EN_ONE)) begin
            rd_value = st_reg.smi_en_one;
        end else if (reg_hit(address, `AUX_IDX_SMI_EN_TWO)) begin
            rd_value = st_reg.smi_en_two;
        end else if (reg_hit(address, `AUX_IDX_SMI_STAT_ONE)) begin
            rd_value = stat_one;
        end else if (reg_hit(address, `AUX_IDX_SMI_STAT_TWO)) begin
            rd_value = stat_two;
        end else if (reg_hit(address, `AUX_IDX_PIN_MUX)) begin
            rd_value = st_reg.pin_mux;
        end else if (reg_hit(address, `AUX_IDX_FORCED_CHG)) begin
            rd_value = {7'h00, st_reg.force_chg};
        end else if (reg_hit(address, `AUX_IDX_EVT_STATUS)) begin
            rd_value = st_reg.evt_status;
        end else if (reg_hit(address, `AUX_IDX_EVT_MASK)) begin
            rd_value = st_reg.evt_mask;
        end
    end

    // ==========================================================
    // next state
    logic ir_clear;
    logic force_set;
    logic force_hw_clr;
    logic [7:0] evt_set;

    always_comb begin
        st_next = st_reg;
        st_next.ack = req && !st_reg.ack;
        if (read && !st_reg.ack) begin
            st_next.rdata = rd_value;
        end

        // clear only the value the reader actually saw; a new edge wins
        ir_clear = rd_acc && reg_hit(address, `AUX_IDX_SMI_STAT_TWO)
            && st_reg.rdata[`AUX_BIT_INFRARED];
        st_next.ir_flag = ir_edge || (st_reg.ir_flag && !ir_clear);

        // write of one sets, zero ignored
        force_set = wr_acc && reg_hit(address, `AUX_IDX_FORCED_CHG)
            && writedata[`AUX_BIT_FORCE_CHG];
        force_hw_clr = !floppy_pins.head_step_n && !floppy_pins.drive_select_zero_n;
        if (force_set) begin
            st_next.force_chg = 1'b1;
        end else if (force_hw_clr) begin
            st_next.force_chg = 1'b0;
        end

        // masked writes keep reserved bits zero
        if (wr_acc && reg_hit(address, `AUX_IDX_PIN_MUX)) begin
            st_next.pin_mux = writedata[7:0] & `AUX_MASK_PIN_MUX;
        end
        if (wr_acc && reg_hit(address, `AUX_IDX_SMI_EN_ONE)) begin
            st_next.smi_en_one = writedata[7:0] & `AUX_MASK_EN_ONE;
        end
        if (wr_acc && reg_hit(address, `AUX_IDX_SMI_EN_TWO)) begin
            st_next.smi_en_two = writedata[7:0] & `AUX_MASK_EN_TWO;
        end
        if (wr_acc && reg_hit(address, `AUX_IDX_EVT_MASK)) begin
            st_next.evt_mask = writedata[7:0] & `AUX_MASK_EVT;
        end

        // sticky events, write one to clear, set beats clear
        evt_set = 8'h00;
        evt_set[`AUX_BIT_EVT_IR] = ir_edge;
        evt_set[`AUX_BIT_EVT_FORCE_CLR] = st_reg.force_chg && !st_next.force_chg;
        st_next.evt_status = st_reg.evt_status;
        if (wr_acc && reg_hit(address, `AUX_IDX_EVT_STATUS)) begin
            st_next.evt_status = st_reg.evt_status & ~writedata[7:0];
        end
        st_next.evt_status = st_next.evt_status | evt_set;

        // hard reset restores pin mux and the keyboard smi enable
        if (hard_reset) begin
            st_next.pin_mux = `AUX_RST_PIN_MUX;
            st_next.smi_en_two = st_next.smi_en_two | `AUX_RST_EN_TWO;
        end
    end

    // ==========================================================
    // state register
    // forced change latch comes up active
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.force_chg <= `AUX_RST_FORCED_CHG;
            st_reg.pin_mux <= `AUX_RST_PIN_MUX;
            st_reg.smi_en_one <= `AUX_RST_EN_ONE;
            st_reg.smi_en_two <= `AUX_RST_EN_TWO;
            st_reg.evt_status <= `AUX_RST_EVT;
            st_reg.evt_mask <= `AUX_RST_EVT;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs
    logic smi_group;

    // media changed combination, pin levels as seen
    assign media_changed_bit = (floppy_pins.drive_select_zero_n && st_reg.force_chg)
        || floppy_pins.media_change_in_n;

    assign smi_group = |(stat_one & st_reg.smi_en_one)
        || |(stat_two & st_reg.smi_en_two & `AUX_MASK_EVT_TWO_SRC);
    assign system_mgmt_irq_n = !smi_group;

    assign dma3_select = st_reg.pin_mux[`AUX_BIT_DMA3_SEL];
    assign kbc_select = st_reg.pin_mux[`AUX_BIT_KBC_SEL];
    assign irq = |(st_reg.evt_status & st_reg.evt_mask);

    // ==========================================================
    // checks
    a_bus_wait_bound: assert property (@(posedge clk) disable iff (srst) // bus
        (req && !st_reg.ack) |=> (!waitrequest || !req))
        else $error("waitrequest held longer than one cycle");

    a_stat_one_layout: assert property (@(posedge clk) disable iff (srst)
        (rd_acc && reg_hit(address, `AUX_IDX_SMI_STAT_ONE) && $stable(stat_one))
        |-> (readdata[7:0] == stat_one && readdata[6:5] == 2'b00))
        else $error("status one read value wrong");

    a_par_inactive_one: assert property (@(posedge clk) disable iff (srst)
        !parallel_port_active |-> stat_one[`AUX_BIT_PARALLEL])
        else $error("parallel flag not one while inactive");

    a_par_tracks_ack: assert property (@(posedge clk) disable iff (srst)
        parallel_port_active |-> (stat_one[`AUX_BIT_PARALLEL] == printer_acknowledge_n))
        else $error("parallel flag not tracking acknowledge");

    a_ir_edge_sets: assert property (@(posedge clk) disable iff (srst)
        ($changed(ir_selected) && !$past(srst))
        |=> st_reg.ir_flag)
        else $error("infrared transition not flagged");

    a_ir_read_clears: assert property (@(posedge clk) disable iff (srst)
        (ir_clear && !ir_edge) |=> !st_reg.ir_flag)
        else $error("infrared flag not cleared by read");

    a_force_set_one: assert property (@(posedge clk) disable iff (srst || hard_reset)
        (wr_acc && reg_hit(address, `AUX_IDX_FORCED_CHG) && writedata[0]) |=> st_reg.force_chg)
        else $error("forced change not set by write");

    a_force_no_sw_clr: assert property (@(posedge clk) disable iff (srst)
        (st_reg.force_chg && !force_hw_clr) |=> st_reg.force_chg)
        else $error("forced change cleared without step");

    a_force_step_clr: assert property (@(posedge clk) disable iff (srst)
        (force_hw_clr && !force_set) |=> !st_reg.force_chg)
        else $error("forced change not cleared by step");

    a_media_changed: assert property (@(posedge clk) disable iff (srst)
        (st_reg.force_chg && floppy_pins.drive_select_zero_n) |-> media_changed_bit)
        else $error("media changed bit wrong");

    a_media_pin_or: assert property (@(posedge clk) disable iff (srst)
        floppy_pins.media_change_in_n |-> media_changed_bit)
        else $error("media changed bit ignores change input");

    a_media_ds0_off: assert property (@(posedge clk) disable iff (srst)
        (!floppy_pins.media_change_in_n && !floppy_pins.drive_select_zero_n) |-> !media_changed_bit)
        else $error("media changed bit set with both terms off");

    a_smi_gated: assert property (@(posedge clk) disable iff (srst)
        (st_reg.smi_en_one == 8'h00 && st_reg.smi_en_two == 8'h00) |-> system_mgmt_irq_n)
        else $error("smi asserted with all enables off");

    a_smi_kbd_gate: assert property (@(posedge clk) disable iff (srst)
        (stat_two[`AUX_BIT_KEYBOARD] && st_reg.smi_en_two[`AUX_BIT_KEYBOARD])
        |-> !system_mgmt_irq_n)
        else $error("enabled keyboard flag did not reach smi");

    a_pin_mux_hard: assert property (@(posedge clk) disable iff (srst)
        hard_reset |=> (st_reg.pin_mux == 8'h02))
        else $error("pin mux not restored by hard reset");

    a_stat_wr_ignored: assert property (@(posedge clk) disable iff (srst)
        (wr_acc && reg_hit(address, `AUX_IDX_SMI_STAT_TWO) && !ir_edge)
        |=> (st_reg.ir_flag == $past(st_reg.ir_flag)))
        else $error("status write changed a flag");

    a_stat_two_bits: assert property (@(posedge clk) disable iff (srst)
        (rd_acc && reg_hit(address, `AUX_IDX_SMI_STAT_TWO))
        |-> (readdata[`AUX_BIT_MOUSE] == $past(sources.mouse_irq_flag)
        && readdata[`AUX_BIT_KEYBOARD] == $past(sources.keyboard_irq_flag)
        && readdata[`AUX_BIT_KBC_P12] == $past(sources.kbc_port1_bit2_flag)))
        else $error("status two source bit wrong");

endmodule

`default_nettype wire

// File: periph_model.sv
// peripheral request sources and floppy drive at the far side of the smi block
`default_nettype none

module periph_model
    import smi_aux_pkg::*;
(
    input wire logic clk,
    input wire irq_sources_t src_cmd,
    input wire logic ack_n_cmd,
    input wire logic ds0_n_cmd,
    input wire logic chg_n_cmd,
    input wire logic step_cmd,
    input wire logic ir_cmd,
    input wire logic ser_cmd,
    output irq_sources_t sources,
    output logic printer_acknowledge_n,
    output logic infrared_receive_in,
    output logic second_serial_receive_in,
    output floppy_pins_t floppy_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] step_cnt;
    initial begin
        step_cnt = 2'h0;
        sources = '0;
        printer_acknowledge_n = 1'b1;
        infrared_receive_in = 1'b0;
        second_serial_receive_in = 1'b0;
        floppy_pins = 3'h7;
    end
    // ==========================================================
    // levels follow the commands one edge later, as a real source would
    always @(posedge clk) begin
        sources <= src_cmd;
        printer_acknowledge_n <= ack_n_cmd;
        infrared_receive_in <= ir_cmd;
        second_serial_receive_in <= ser_cmd;
        floppy_pins.drive_select_zero_n <= ds0_n_cmd;
        floppy_pins.media_change_in_n <= chg_n_cmd;
        // step is a low pulse of three cycles, never shorter
        if (step_cmd && step_cnt == 2'h0) begin
            step_cnt <= 2'h3;
        end else if (step_cnt != 2'h0) begin
            step_cnt <= step_cnt - 2'h1;
        end
        floppy_pins.head_step_n <= (step_cnt == 2'h0);
    end
endmodule

`default_nettype wire

// File: tb.sv
// self-checking bench for the smi auxiliary register block
`default_nettype none

module tb
    import smi_aux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, hard_reset = 1'b0, read = 1'b0, write = 1'b0;
    logic [9:0] address = 10'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest, media_changed_bit, system_mgmt_irq_n, dma3_select, kbc_select, irq;
    logic parallel_port_active = 1'b0, ir_input_select = 1'b1;
    logic ack_n_cmd = 1'b0, ds0_n_cmd = 1'b1, chg_n_cmd = 1'b0;
    logic step_cmd = 1'b0, ir_cmd = 1'b0, ser_cmd = 1'b0;
    logic infrared_receive_in, second_serial_receive_in, printer_acknowledge_n;
    irq_sources_t src_cmd = '0;
    irq_sources_t sources;
    floppy_pins_t floppy_pins;
    int fails = 0;
    int checked = 0;
    logic [7:0] exp_one [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h10, 8'h08, 8'h04};
    logic [7:0] exp_two [7] = '{8'h10, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

    always #20 clk = ~clk;

    smi_aux_top dut_u (.clk(clk), .srst(srst), .hard_reset(hard_reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest), .sources(sources),
        .parallel_port_active(parallel_port_active), .printer_acknowledge_n(printer_acknowledge_n),
        .ir_input_select(ir_input_select), .infrared_receive_in(infrared_receive_in),
        .second_serial_receive_in(second_serial_receive_in), .floppy_pins(floppy_pins),
        .media_changed_bit(media_changed_bit), .system_mgmt_irq_n(system_mgmt_irq_n),
        .dma3_select(dma3_select), .kbc_select(kbc_select), .irq(irq));

    periph_model model_u (.clk(clk), .src_cmd(src_cmd), .ack_n_cmd(ack_n_cmd),
        .ds0_n_cmd(ds0_n_cmd), .chg_n_cmd(chg_n_cmd), .step_cmd(step_cmd), .ir_cmd(ir_cmd),
        .ser_cmd(ser_cmd), .sources(sources), .printer_acknowledge_n(printer_acknowledge_n),
        .infrared_receive_in(infrared_receive_in),
        .second_serial_receive_in(second_serial_receive_in), .floppy_pins(floppy_pins));

    // ==========================================================
    // reporting
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ==========================================================
    // avalon-mm master: hold until waitrequest is sampled low
    task automatic bus_op(input logic rd, input logic [7:0] idx, input logic [7:0] wd,
                          output logic [7:0] rdat);
        int n;
        n = 0;
        address <= {idx, 2'h0};
        writedata <= {24'h0, wd};
        read <= rd;
        write <= !rd;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 200);
        rdat = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 200) begin
            fails++;
            $display("wrong value at %0t: bus wait ran out", $time);
            conclude();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus_op(1'b0, idx, wd, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] d;
        bus_op(1'b1, idx, 8'h00, d);
        chk(d, exp, what);
    endtask

    // 0 infrared, 1 serial, else step; a task argument cannot take a nonblocking drive
    task automatic pulse(input int which);
        case (which)
            0: ir_cmd <= 1'b1;
            1: ser_cmd <= 1'b1;
            default: step_cmd <= 1'b1;
        endcase
        tick(3);
        ir_cmd <= 1'b0;
        ser_cmd <= 1'b0;
        step_cmd <= 1'b0;
        tick(3);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        tick(20);
        srst <= 1'b0;
        tick(2);
        rdchk(8'hB6, 8'h02, "stat one reset"); // inactive port reads one
        rdchk(8'hB7, 8'h00, "stat two reset"); // sources idle
        rdchk(8'hB8, 8'h00, "rsvd reset"); // reserved reads zero
        rdchk(8'hC0, 8'h02, "pin mux reset"); // reset value
        rdchk(8'hC1, 8'h01, "force reset"); // latch starts active
        rdchk(8'hD0, 8'h00, "evt reset");
        chk({7'h0, dma3_select}, 8'h01, "dma3 out"); // follows bit 1
        chk({7'h0, system_mgmt_irq_n}, 8'h01, "smi idle"); // no enabled flag set
        $display("test reset done");
        parallel_port_active <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            src_cmd <= irq_sources_t'(7'h01 << k);
            tick(3);
            rdchk(8'hB6, exp_one[k], "stat one bit"); // bit position, ack low
            rdchk(8'hB7, exp_two[k], "stat two bit"); // bit position
        end
        src_cmd <= 7'h40;
        wr(8'hB6, 8'h00);
        rdchk(8'hB6, 8'h04, "stat one write"); // write has no effect
        wr(8'hB4, 8'h04);
        tick(2);
        chk({7'h0, system_mgmt_irq_n}, 8'h00, "smi enabled"); // enabled flag asserts
        wr(8'hB4, 8'hFB);
        rdchk(8'hB4, 8'h9A, "en one mask"); // enable bits only
        chk({7'h0, system_mgmt_irq_n}, 8'h01, "smi disabled"); // disabled flag blocked
        src_cmd <= 7'h00;
        ack_n_cmd <= 1'b1;
        tick(3);
        rdchk(8'hB6, 8'h02, "ack high"); // cleared at source, tracks ack
        parallel_port_active <= 1'b0;
        ack_n_cmd <= 1'b0;
        tick(3);
        rdchk(8'hB6, 8'h02, "port off"); // inactive port reads one
        wr(8'hB4, 8'h00);
        $display("test status done");
        src_cmd <= 7'h02;
        pulse(0);
        rdchk(8'hB7, 8'h06, "ir set"); // transition on selected line
        rdchk(8'hB7, 8'h02, "ir read clr"); // read clears ir, keyboard stays
        chk({7'h0, system_mgmt_irq_n}, 8'h00, "smi kbd"); // keyboard enabled by reset
        pulse(1);
        rdchk(8'hB7, 8'h02, "ir unselected"); // other line ignored
        ir_input_select <= 1'b0;
        tick(2);
        pulse(1);
        rdchk(8'hB7, 8'h06, "ir serial"); // mux picks serial line
        src_cmd <= 7'h00;
        $display("test infrared done");
        rdchk(8'hD0, 8'h01, "evt ir"); // transition also logged
        chk({7'h0, irq}, 8'h00, "irq masked");
        wr(8'hD1, 8'h03);
        tick(2);
        chk({7'h0, irq}, 8'h01, "irq raised");
        wr(8'hD0, 8'h01);
        tick(2);
        chk({7'h0, irq}, 8'h00, "irq cleared");
        rdchk(8'hD0, 8'h00, "evt cleared");
        $display("test interrupt done");
        chk({7'h0, media_changed_bit}, 8'h01, "media ds0 high"); // ds0 and latch
        wr(8'hC1, 8'h00);
        rdchk(8'hC1, 8'h01, "force no clear"); // zero does not clear
        pulse(2);
        rdchk(8'hC1, 8'h01, "step unselected"); // needs drive select zero
        ds0_n_cmd <= 1'b0;
        tick(3);
        chk({7'h0, media_changed_bit}, 8'h00, "media ds0 low"); // and term off
        pulse(2);
        rdchk(8'hC1, 8'h00, "step clears"); // step with select clears latch
        rdchk(8'hD0, 8'h02, "evt force clr"); // clear logged
        ds0_n_cmd <= 1'b1;
        tick(3);
        chk({7'h0, media_changed_bit}, 8'h00, "media latch off"); // latch zero
        chg_n_cmd <= 1'b1;
        tick(3);
        chk({7'h0, media_changed_bit}, 8'h01, "media chg pin"); // or term
        wr(8'hC1, 8'hFF);
        rdchk(8'hC1, 8'h01, "force set"); // one sets, reserved zero
        $display("test force change done");
        wr(8'hC0, 8'hFF);
        rdchk(8'hC0, 8'h0A, "pin mux write"); // only bits 1 and 3 hold
        chk({7'h0, kbc_select}, 8'h01, "kbc out"); // follows bit 3
        hard_reset <= 1'b1;
        tick(2);
        hard_reset <= 1'b0;
        tick(2);
        rdchk(8'hC0, 8'h02, "pin mux hard"); // hard reset restores
        wr(8'h50, 8'hFF);
        rdchk(8'h50, 8'h00, "unmapped"); // unmapped reads zero
        wr(8'hB8, 8'hFF);
        rdchk(8'hB8, 8'h00, "rsvd write"); // reserved ignores writes
        $display("test misc done");
        conclude();
    end
endmodule

`default_nettype wire
